// file: rtl/boot_loader_defines.vh
// Constants for the boot command interpreter
`ifndef BOOT_LOADER_DEFINES_VH
`define BOOT_LOADER_DEFINES_VH
`define BOOT_ROM_ENTRY      20'h20000
`define BOOT_ROM_MAIN       20'h20400
`define USER_START_DUAL_PORT_RAM   20'h00000
`define USER_START_EXTERNAL_ROM_SEGMENT    20'h80000
`define HANDSHAKE_VALUE    8'hED
`define WAIT_ERAM          16'h0030
`define WAIT_SET0          16'h0111
`define WAIT_SET1          16'h0222
`define WAIT_SET2          16'h0444
`define WAIT_SET3          16'h0FFF
`define COPY_WORDS         17'h0F000
`define CMD_ERAM_HI        8'h18
`define CMD_ERAM_LO_A      8'h58
`define CMD_ERAM_LO_B      8'h98
`define CMD_START_DUAL_PORT_RAM    8'h40
`define CMD_START_EXTERNAL_ROM_SEGMENT     8'h41
`define SRC_ERAM_HI        2'h0
`define SRC_ERAM_LO        2'h1
`define SRC_IO             2'h2
`define SRC_EXTERNAL_ROM_SEGMENT           2'h3
`define STROBE_SEPARATE    1'b0
`define STROBE_RW          1'b1
`define DMA_LEN_1          10'h001
`define DMA_LEN_64         10'h040
`define DMA_LEN_512        10'h200
`endif

// file: rtl/host_strobe_edge.v
// Rising edge detector for a host strobe, gated by chip select
`timescale 1ns/1ns
module host_strobe_edge
(
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  // Strobe and chip select levels
  input  wire strobe_level,
  input  wire cs_n,
  // Pulse when strobe or select rises, whichever first
  output reg  rise_pulse
);
  reg active_r;
  wire active_now;
  assign active_now = ~strobe_level & ~cs_n;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      active_r   <= 1'b0;
      rise_pulse <= 1'b0;
    end
    else
    begin
      active_r   <= active_now;
      rise_pulse <= active_r & ~active_now;
    end
  end
endmodule

// file: rtl/boot_host_command_loader.v
// Boot command interpreter driven from the parallel host port
`timescale 1ns/1ns
`include "boot_loader_defines.vh"
module boot_host_command_loader
#(
  parameter COPY_LEN = `COPY_WORDS
)
(
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  // Boot select strap
  input  wire        external_boot_select,
  // Parallel host port
  input  wire [15:0] host_data_bus_in,
  output reg  [15:0] host_data_bus_out,
  output reg         host_data_bus_oe_n,
  input  wire        host_chip_select_n,
  input  wire        host_input_strobe,
  input  wire        host_output_strobe,
  input  wire        abort_interrupt_pin,
  output reg         out_buffer_empty_flag,
  // Host port control fields
  output reg         bus_width_field,
  output reg         transfer_config_field,
  output reg         byte_swap_field,
  output reg         strobe_style_field,
  output reg         strobe_active_high,
  output reg         abort_enable,
  output reg         pll_enable,
  // Program fetch and mode
  output reg  [19:0] fetch_address,
  output reg         boot_mode,
  output reg         peripheral_reinit,
  // External memory and DMA setup
  output reg  [15:0] ext_wait_setting,
  output reg  [1:0]  copy_source,
  output reg         copy_active,
  output reg         download_active,
  output reg  [9:0]  dma_input_length,
  // Dual port RAM write
  output reg  [16:0] dual_port_ram_addr,
  output reg  [15:0] dual_port_ram_wdata,
  output reg         dual_port_ram_we,
  // Copy source read data
  input  wire [15:0] copy_rdata
);
  // ****************************************
  // State machine
  // ****************************************
  localparam ST_ENTRY = 7'b0000001;
  localparam ST_MAIN  = 7'b0000010;
  localparam ST_IDLE  = 7'b0000100;
  localparam ST_COPY  = 7'b0001000;
  localparam ST_LOAD  = 7'b0010000;
  localparam ST_HAND  = 7'b0100000;
  localparam ST_USER  = 7'b1000000;

  reg [6:0]  state_r;
  reg [6:0]  state_nxt;
  reg [16:0] count_r;
  reg        hi_byte_r;
  reg [7:0]  low_byte_r;
  reg        strap_done_r;

  wire in_rise;
  wire out_rise;
  wire in_level;
  wire load_word;

  // Read/write-strobe mode: write when the rw line is low (high if strobe_active_high) during data strobe
  assign in_level = (strobe_style_field == `STROBE_RW) ?
                    (host_input_strobe | ~(host_output_strobe ^ ~strobe_active_high)) :
                    host_input_strobe;

  // Word complete, except for the low byte of a 16-bit pair on the 8-bit bus
  assign load_word = in_rise & ~(transfer_config_field & ~bus_width_field & ~hi_byte_r);

  host_strobe_edge u_in_edge
  (
    .clk          (clk),
    .rstn         (rstn),
    .strobe_level (in_level),
    .cs_n         (host_chip_select_n),
    .rise_pulse   (in_rise)
  );

  host_strobe_edge u_out_edge
  (
    .clk          (clk),
    .rstn         (rstn),
    .strobe_level (host_output_strobe ^ strobe_active_high),
    .cs_n         (host_chip_select_n),
    .rise_pulse   (out_rise)
  );

  // ****************************************
  // Command decode
  // ****************************************
  reg        dec_copy;
  reg        dec_load;
  reg        dec_start;
  reg        dec_start_external_rom_segment;
  reg [15:0] dec_wait;
  reg [1:0]  dec_src;
  reg        dec_width;
  reg        dec_cfg;
  reg        dec_swap;
  reg [9:0]  dec_len;
  reg [1:0]  dec_sub;
  wire [7:0] cmd;
  assign cmd = host_data_bus_in[7:0];

  always @*
  begin
    dec_copy       = 1'b0;
    dec_load       = 1'b0;
    dec_start      = 1'b0;
    dec_start_external_rom_segment = 1'b0;
    dec_wait       = `WAIT_ERAM;
    dec_src        = `SRC_ERAM_HI;
    dec_width      = 1'b0;
    dec_cfg        = 1'b0;
    dec_swap       = 1'b0;
    dec_len        = `DMA_LEN_1;
    dec_sub        = 2'h0;
    case (cmd[7:6])
      2'h0:    dec_wait = `WAIT_SET0;
      2'h1:    dec_wait = `WAIT_SET1;
      2'h2:    dec_wait = `WAIT_SET2;
      default: dec_wait = `WAIT_SET3;
    endcase
    case (cmd)
      `CMD_ERAM_HI:
      begin
        dec_copy = 1'b1;
        dec_wait = `WAIT_ERAM;
        dec_src  = `SRC_ERAM_HI;
      end
      `CMD_ERAM_LO_A, `CMD_ERAM_LO_B:
      begin
        dec_copy = 1'b1;
        dec_wait = `WAIT_ERAM;
        dec_src  = `SRC_ERAM_LO;
      end
      8'h19, 8'h59, 8'h99, 8'hD9:
      begin
        dec_copy = 1'b1;
        dec_src  = `SRC_IO;
      end
      8'h1B, 8'h5B, 8'h9B, 8'hDB:
      begin
        dec_copy = 1'b1;
        dec_src  = `SRC_EXTERNAL_ROM_SEGMENT;
      end
      8'h01, 8'h02, 8'h03:
      begin
        dec_load = 1'b1;
        dec_sub  = cmd[1:0] - 2'h1;
      end
      8'h06, 8'h07, 8'h08:
      begin
        dec_load = 1'b1;
        dec_cfg  = 1'b1;
        dec_sub  = cmd[1:0] - 2'h2;
      end
      8'h09, 8'h0A, 8'h0B:
      begin
        dec_load  = 1'b1;
        dec_width = 1'b1;
        dec_cfg   = 1'b1;
        dec_sub   = cmd[1:0] - 2'h1;
      end
      8'h0C, 8'h0D, 8'h0E:
      begin
        dec_load  = 1'b1;
        dec_width = 1'b1;
        dec_cfg   = 1'b1;
        dec_len   = `DMA_LEN_64;
        dec_sub   = cmd[1:0];
      end
      8'h0F, 8'h10, 8'h11:
      begin
        dec_load  = 1'b1;
        dec_width = 1'b1;
        dec_cfg   = 1'b1;
        dec_len   = `DMA_LEN_512;
        dec_sub   = (cmd == 8'h0F) ? 2'h0 : ((cmd == 8'h10) ? 2'h1 : 2'h2);
      end
      8'h16, 8'h17:
      begin
        dec_load  = 1'b1;
        dec_width = 1'b1;
        dec_cfg   = 1'b1;
        dec_swap  = 1'b1;
        dec_sub   = {1'b0, cmd[0]};
      end
      8'h1C, 8'h1D:
      begin
        dec_load  = 1'b1;
        dec_width = 1'b1;
        dec_cfg   = 1'b1;
        dec_swap  = 1'b1;
        dec_len   = `DMA_LEN_64;
        dec_sub   = {1'b0, cmd[0]};
      end
      `CMD_START_DUAL_PORT_RAM:
        dec_start = 1'b1;
      `CMD_START_EXTERNAL_ROM_SEGMENT:
      begin
        dec_start      = 1'b1;
        dec_start_external_rom_segment = 1'b1;
      end
      default:
        dec_copy = 1'b0;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_ENTRY:
        if (strap_done_r)
          state_nxt = ST_MAIN;
      ST_MAIN:
        state_nxt = ST_IDLE;
      ST_IDLE:
        if (in_rise)
        begin
          if (dec_copy)
            state_nxt = ST_COPY;
          else if (dec_load)
            state_nxt = ST_LOAD;
          else if (dec_start)
            state_nxt = ST_USER;
          else
            state_nxt = ST_HAND;
        end
      ST_COPY:
        if (abort_interrupt_pin || count_r == COPY_LEN - 17'h1)
          state_nxt = ST_HAND;
      ST_LOAD:
        if (abort_interrupt_pin || (load_word && count_r == COPY_LEN - 17'h1))
          state_nxt = ST_HAND;
      ST_HAND:
        if (out_rise)
          state_nxt = ST_IDLE;
      ST_USER:
        state_nxt = ST_USER;
      default:
        state_nxt = ST_ENTRY;
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r               <= ST_ENTRY;
      strap_done_r          <= 1'b0;
      count_r               <= 17'h00000;
      hi_byte_r             <= 1'b0;
      low_byte_r            <= 8'h00;
      host_data_bus_out     <= 16'h0000;
      host_data_bus_oe_n    <= 1'b1;
      out_buffer_empty_flag <= 1'b1;
      bus_width_field       <= 1'b0;
      transfer_config_field <= 1'b0;
      byte_swap_field       <= 1'b0;
      strobe_style_field    <= `STROBE_SEPARATE;
      strobe_active_high    <= 1'b0;
      abort_enable          <= 1'b0;
      pll_enable            <= 1'b0;
      fetch_address         <= 20'h00000;
      boot_mode             <= 1'b0;
      peripheral_reinit     <= 1'b0;
      ext_wait_setting      <= 16'h0000;
      copy_source           <= 2'h0;
      copy_active           <= 1'b0;
      download_active       <= 1'b0;
      dma_input_length      <= `DMA_LEN_1;
      dual_port_ram_addr            <= 17'h00000;
      dual_port_ram_wdata           <= 16'h0000;
      dual_port_ram_we              <= 1'b0;
    end
    else
    begin
      state_r           <= state_nxt;
      dual_port_ram_we          <= 1'b0;
      peripheral_reinit <= 1'b0;
      host_data_bus_oe_n <= ~(out_buffer_empty_flag == 1'b0 && ~host_chip_select_n &&
                              ~host_output_strobe);
      if (!strap_done_r)
      begin
        strap_done_r <= 1'b1;
        boot_mode    <= ~external_boot_select;
        if (!external_boot_select)
          fetch_address <= `BOOT_ROM_ENTRY;
        else
          state_r <= ST_USER;
      end
      else
      begin
        case (state_r)
          ST_ENTRY:
            fetch_address <= `BOOT_ROM_MAIN;
          ST_MAIN:
          begin
            bus_width_field       <= 1'b0;
            transfer_config_field <= 1'b0;
            strobe_style_field    <= `STROBE_SEPARATE;
            strobe_active_high    <= 1'b0;
            abort_enable          <= 1'b1;
            pll_enable            <= 1'b0;
          end
          ST_IDLE:
            if (in_rise)
            begin
              count_r   <= 17'h00000;
              hi_byte_r <= 1'b0;
              if (dec_copy)
              begin
                ext_wait_setting <= dec_wait;
                copy_source      <= dec_src;
                copy_active      <= 1'b1;
              end
              if (dec_load)
              begin
                download_active       <= 1'b1;
                bus_width_field       <= dec_width;
                transfer_config_field <= dec_cfg;
                byte_swap_field       <= dec_swap;
                dma_input_length      <= dec_len;
                strobe_style_field    <= (dec_sub == 2'h2) ? `STROBE_SEPARATE :
                                         `STROBE_RW;
                strobe_active_high    <= (dec_sub == 2'h1);
              end
              if (dec_start)
              begin
                boot_mode             <= 1'b0;
                fetch_address         <= dec_start_external_rom_segment ? `USER_START_EXTERNAL_ROM_SEGMENT :
                                         `USER_START_DUAL_PORT_RAM;
                peripheral_reinit     <= 1'b1;
                bus_width_field       <= 1'b0;
                transfer_config_field <= 1'b0;
                strobe_style_field    <= `STROBE_SEPARATE;
              end
            end
          ST_COPY:
          begin
            dual_port_ram_addr  <= count_r;
            dual_port_ram_wdata <= copy_rdata;
            dual_port_ram_we    <= ~abort_interrupt_pin;
            count_r     <= count_r + 17'h1;
          end
          ST_LOAD:
            if (in_rise)
            begin
              if (transfer_config_field && !bus_width_field && !hi_byte_r)
              begin
                hi_byte_r  <= 1'b1;
                low_byte_r <= host_data_bus_in[7:0];
              end
              else
              begin
                hi_byte_r  <= 1'b0;
                dual_port_ram_addr <= count_r;
                dual_port_ram_we   <= 1'b1;
                count_r    <= count_r + 17'h1;
                if (!transfer_config_field)
                  dual_port_ram_wdata <= {8'h00, host_data_bus_in[7:0]};
                else if (!bus_width_field)
                  dual_port_ram_wdata <= {host_data_bus_in[7:0], low_byte_r};
                else if (byte_swap_field)
                  dual_port_ram_wdata <= {host_data_bus_in[7:0], host_data_bus_in[15:8]};
                else
                  dual_port_ram_wdata <= host_data_bus_in;
              end
            end
          ST_HAND:
            if (out_rise)
            begin
              out_buffer_empty_flag <= 1'b1;
              bus_width_field       <= 1'b0;
              transfer_config_field <= 1'b0;
              byte_swap_field       <= 1'b0;
              strobe_style_field    <= `STROBE_SEPARATE;
              strobe_active_high    <= 1'b0;
            end
          default:
            count_r <= count_r;
        endcase
        if (state_nxt == ST_HAND && state_r != ST_HAND)
        begin
          host_data_bus_out     <= {8'h00, `HANDSHAKE_VALUE};
          out_buffer_empty_flag <= 1'b0;
          copy_active           <= 1'b0;
          download_active       <= 1'b0;
          // Host reads the handshake in the initial port mode
          bus_width_field       <= 1'b0;
          transfer_config_field <= 1'b0;
          byte_swap_field       <= 1'b0;
          strobe_style_field    <= `STROBE_SEPARATE;
          strobe_active_high    <= 1'b0;
        end
      end
    end
  end
endmodule

// file: verif/boot_loader_asserts.sv
// Port-level checks for the boot command interpreter
`timescale 1ns/1ns
`include "boot_loader_defines.vh"
module boot_loader_asserts
#(
  parameter COPY_LEN = `COPY_WORDS
)
(
  // Clock, reset and strap
  input wire        clk,
  input wire        rstn,
  input wire        external_boot_select,
  // Host port
  input wire [15:0] host_data_bus_out,
  input wire        host_chip_select_n,
  input wire        abort_interrupt_pin,
  input wire        out_buffer_empty_flag,
  // Mode and routine state
  input wire        bus_width_field,
  input wire        strobe_style_field,
  input wire        abort_enable,
  input wire        pll_enable,
  input wire [19:0] fetch_address,
  input wire        boot_mode,
  input wire [15:0] ext_wait_setting,
  input wire [1:0]  copy_source,
  input wire        copy_active,
  input wire        download_active,
  input wire [16:0] dual_port_ram_addr,
  input wire        dual_port_ram_we
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_boot_entry;
    $rose(rstn) && !external_boot_select |=>
      fetch_address == `BOOT_ROM_ENTRY ##1 fetch_address == `BOOT_ROM_MAIN;
  endproperty
  a_boot_entry: assert property (p_boot_entry)
    else $error("boot entry fetch sequence wrong");
  property p_port_init;
    $rose(rstn) && !external_boot_select |-> ##3 abort_enable && !pll_enable
      && !bus_width_field && strobe_style_field == `STROBE_SEPARATE;
  endproperty
  a_port_init: assert property (p_port_init)
    else $error("port not set up on boot entry");
  property p_handshake;
    $fell(out_buffer_empty_flag) |-> host_data_bus_out == {8'h00, `HANDSHAKE_VALUE};
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("handshake value missing");
  property p_stall;
    !out_buffer_empty_flag |=> !$rose(copy_active) && !$rose(download_active);
  endproperty
  a_stall: assert property (p_stall)
    else $error("routine started before handshake read");
  property p_flag_hold;
    (!out_buffer_empty_flag && host_chip_select_n) [*4] |=> !out_buffer_empty_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("empty flag set without host read");
  property p_abort;
    abort_interrupt_pin && (copy_active || download_active)
      |-> ##[1:4] !(copy_active || download_active);
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort did not end routine");
  property p_copy_addr;
    dual_port_ram_we && copy_active |-> dual_port_ram_addr < COPY_LEN;
  endproperty
  a_copy_addr: assert property (p_copy_addr)
    else $error("copy beyond segment length");
  property p_wait_ram;
    $rose(copy_active) && copy_source <= `SRC_ERAM_LO |-> ext_wait_setting == `WAIT_ERAM;
  endproperty
  a_wait_ram: assert property (p_wait_ram)
    else $error("wrong wait setting for RAM copy");
  property p_wait_other;
    $rose(copy_active) && copy_source >= `SRC_IO |-> ext_wait_setting inside
      {`WAIT_SET0, `WAIT_SET1, `WAIT_SET2, `WAIT_SET3};
  endproperty
  a_wait_other: assert property (p_wait_other)
    else $error("wrong wait setting for copy");
  property p_exit;
    $fell(boot_mode) |-> ##[0:2] (fetch_address == `USER_START_DUAL_PORT_RAM
      || fetch_address == `USER_START_EXTERNAL_ROM_SEGMENT);
  endproperty
  a_exit: assert property (p_exit)
    else $error("user start address wrong");
endmodule

// file: verif/host_port_model.sv
// Host processor model driving the parallel host port
`timescale 1ns/1ns
module host_port_model
(
  // Clock and device outputs
  input  wire        clk,
  input  wire [15:0] host_data_bus_out,
  input  wire        host_data_bus_oe_n,
  input  wire [16:0] dual_port_ram_addr,
  // Host driven lines
  output reg  [15:0] host_data_bus_in,
  output reg         host_chip_select_n,
  output reg         host_input_strobe,
  output reg         host_output_strobe,
  output reg         abort_interrupt_pin,
  output wire [15:0] copy_rdata
);
  reg  [15:0] drv;
  reg         drv_en;
  initial
  begin
    drv = 16'h0000;
    drv_en = 1'b0;
    host_chip_select_n = 1'b1;
    host_input_strobe = 1'b1;
    host_output_strobe = 1'b1;
    abort_interrupt_pin = 1'b0;
  end
  // Released bus shows the inverse of the last driven value
  always @*
    host_data_bus_in = !host_data_bus_oe_n ? host_data_bus_out : (drv_en ? drv : ~drv);
  assign copy_rdata = {~dual_port_ram_addr[7:0], dual_port_ram_addr[7:0]};
  task put(input logic [15:0] d);
    begin
      @(posedge clk);
      drv <= d;
      drv_en <= 1'b1;
      host_chip_select_n <= 1'b0;
      host_input_strobe <= 1'b0;
      @(posedge clk);
      host_chip_select_n <= 1'b1;
      host_input_strobe <= 1'b1;
      repeat (3) @(posedge clk);
      drv_en <= 1'b0;
    end
  endtask
  task get(output logic [15:0] d);
    begin
      @(posedge clk);
      host_chip_select_n <= 1'b0;
      host_output_strobe <= 1'b0;
      repeat (2) @(posedge clk);
      d = host_data_bus_in;
      host_chip_select_n <= 1'b1;
      host_output_strobe <= 1'b1;
    end
  endtask
  task stop;
    begin
      @(posedge clk);
      abort_interrupt_pin <= 1'b1;
      repeat (2) @(posedge clk);
      abort_interrupt_pin <= 1'b0;
    end
  endtask
endmodule

// file: verif/boot_host_command_loader_tb_top.sv
// Self-checking bench for the boot command interpreter
`timescale 1ns/1ns
`include "boot_loader_defines.vh"
module boot_host_command_loader_tb_top;
  localparam int CLEN = 8;
  localparam logic [7:0] CC [11] = '{8'h18, 8'h58, 8'h98, 8'h19, 8'h59, 8'h99, 8'hD9,
                                     8'h1B, 8'h5B, 8'h9B, 8'hDB};
  localparam logic [7:0] DC [19] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09,
                                     8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10,
                                     8'h11, 8'h16, 8'h17, 8'h1C, 8'h1D};
  localparam logic [15:0] WT [4] = '{`WAIT_SET0, `WAIT_SET1, `WAIT_SET2, `WAIT_SET3};
  localparam logic [7:0] LC [3] = '{8'h03, 8'h08, 8'h11};
  localparam logic [15:0] LW [3] = '{16'h0007, 16'h0F0E, 16'hC007};
  reg         clk;
  reg         rstn = 1'b0;
  reg         external_boot_select = 1'b0;
  wire [15:0] host_data_bus_in, host_data_bus_out, ext_wait_setting, dual_port_ram_wdata, copy_rdata;
  wire        host_data_bus_oe_n, host_chip_select_n, host_input_strobe, host_output_strobe;
  wire        abort_interrupt_pin, out_buffer_empty_flag, bus_width_field, transfer_config_field;
  wire        byte_swap_field, strobe_style_field, strobe_active_high, abort_enable, pll_enable;
  wire        boot_mode, peripheral_reinit, copy_active, download_active, dual_port_ram_we;
  wire [19:0] fetch_address;
  wire [1:0]  copy_source;
  wire [9:0]  dma_input_length;
  wire [16:0] dual_port_ram_addr;
  integer     n_mismatch = 0;
  integer     cmp_count = 0;
  integer     nwe = 0;
  integer     i;
  integer     k;
  integer     p;
  reg         seen_reinit = 1'b0;
  reg  [15:0] rd;
  boot_host_command_loader #(.COPY_LEN(CLEN)) i_boot_host_command_loader (
    .clk, .rstn, .external_boot_select, .host_data_bus_in, .host_data_bus_out,
    .host_data_bus_oe_n, .host_chip_select_n, .host_input_strobe, .host_output_strobe,
    .abort_interrupt_pin, .out_buffer_empty_flag, .bus_width_field, .transfer_config_field,
    .byte_swap_field, .strobe_style_field, .strobe_active_high, .abort_enable, .pll_enable,
    .fetch_address, .boot_mode, .peripheral_reinit, .ext_wait_setting, .copy_source,
    .copy_active, .download_active, .dma_input_length, .dual_port_ram_addr, .dual_port_ram_wdata, .dual_port_ram_we,
    .copy_rdata);
  host_port_model i_host_port_model (
    .clk, .host_data_bus_out, .host_data_bus_oe_n, .dual_port_ram_addr, .host_data_bus_in,
    .host_chip_select_n, .host_input_strobe, .host_output_strobe, .abort_interrupt_pin,
    .copy_rdata);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (dual_port_ram_we === 1'b1) nwe = nwe + 1;
    if (peripheral_reinit === 1'b1) seen_reinit = 1'b1;
  end
  task report_and_stop;
    begin
      $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s: expected %0h, seen %0h", what, exp, seen);
      end
    end
  endtask
  task do_reset;
    begin
      @(posedge clk);
      rstn <= 1'b0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (5) @(posedge clk);
    end
  endtask
  task wait_empty(input logic v, input integer lim);
    begin
      for (k = 0; k < lim && out_buffer_empty_flag !== v; k = k + 1) @(negedge clk);
      check(out_buffer_empty_flag, v, "empty flag");
    end
  endtask
  task wait_busy;
    begin
      for (k = 0; k < 20 && (copy_active | download_active) !== 1'b1; k = k + 1) @(negedge clk);
      check(copy_active | download_active, 1'b1, "routine busy");
    end
  endtask
  task handshake;
    begin
      wait_empty(1'b0, 80);
      check(host_data_bus_out, {8'h00, `HANDSHAKE_VALUE}, "handshake");
      i_host_port_model.get(rd);
      check(rd, 16'h00ED, "bus read");
      wait_empty(1'b1, 12);
      check({bus_width_field, transfer_config_field, strobe_style_field}, 3'h0, "mode");
    end
  endtask
  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    report_and_stop;
  end
  initial
  begin
    do_reset;
    check(fetch_address, `BOOT_ROM_MAIN, "fetch address");
    check({abort_enable, pll_enable, bus_width_field, strobe_style_field}, 4'h8, "entry");
    $display("test boot entry done");
    i_host_port_model.put(16'h0005);
    wait_empty(1'b0, 20);
    check({copy_active, download_active}, 2'h0, "no transfer");
    i_host_port_model.put(16'h0018);
    repeat (4) @(posedge clk);
    check(copy_active, 1'b0, "refused command");
    handshake;
    $display("test undefined command done");
    for (i = 0; i < 11; i = i + 1)
    begin
      nwe = 0;
      i_host_port_model.put({8'h00, CC[i]});
      wait_busy;
      check(ext_wait_setting, i < 3 ? `WAIT_ERAM : WT[(i - 3) % 4], "wait");
      check(copy_source, i < 1 ? 0 : i < 3 ? 1 : i < 7 ? 2 : 3, "source");
      handshake;
      check(nwe, CLEN, "copy length");
    end
    nwe = 0;
    i_host_port_model.put(16'h001B);
    i_host_port_model.stop;
    handshake;
    check(nwe < CLEN, 1'b1, "aborted copy");
    $display("test copy done");
    for (i = 0; i < 19; i = i + 1)
    begin
      p = i < 15 ? i % 3 : (i - 15) % 2;
      i_host_port_model.put({8'h00, DC[i]});
      wait_busy;
      check({bus_width_field, transfer_config_field, byte_swap_field, strobe_style_field,
             strobe_active_high}, {i >= 6, i >= 3, i >= 15, p != 2, p == 1}, "config");
      check(dma_input_length, ((i >= 9 && i < 12) || i >= 17) ? `DMA_LEN_64 :
            (i >= 12 && i < 15) ? `DMA_LEN_512 : `DMA_LEN_1, "dma length");
      i_host_port_model.stop;
      handshake;
    end
    nwe = 0;
    for (p = 0; p < 3; p = p + 1)
    begin
      nwe = 0;
      i_host_port_model.put({8'h00, LC[p]});
      for (i = 0; i < (p == 1 ? 2 * CLEN : CLEN); i = i + 1)
        i_host_port_model.put(16'hC000 + i[15:0]);
      handshake;
      check(nwe, CLEN, "download words");
      check(dual_port_ram_wdata, LW[p], "last word");
      check(dual_port_ram_addr, CLEN - 1, "last address");
    end
    $display("test download done");
    for (i = 0; i < 2; i = i + 1)
    begin
      do_reset;
      seen_reinit = 1'b0;
      i_host_port_model.put({8'h00, `CMD_START_DUAL_PORT_RAM + i[7:0]});
      @(negedge clk);
      for (k = 0; k < 20 && boot_mode !== 1'b0; k = k + 1) @(negedge clk);
      check(boot_mode, 1'b0, "boot exit");
      check(fetch_address, i ? `USER_START_EXTERNAL_ROM_SEGMENT : `USER_START_DUAL_PORT_RAM, "user start");
      check(seen_reinit, 1'b1, "reinit pulse");
    end
    @(posedge clk);
    external_boot_select <= 1'b1;
    do_reset;
    i_host_port_model.put(16'h0005);
    wait_empty(1'b1, 4);
    check(boot_mode, 1'b0, "strap high");
    $display("test start done");
    report_and_stop;
  end
endmodule
bind boot_host_command_loader boot_loader_asserts #(.COPY_LEN(COPY_LEN)) i_boot_loader_asserts (
  .clk, .rstn, .external_boot_select, .host_data_bus_out, .host_chip_select_n,
  .abort_interrupt_pin, .out_buffer_empty_flag, .bus_width_field, .strobe_style_field,
  .abort_enable, .pll_enable, .fetch_address, .boot_mode, .ext_wait_setting, .copy_source,
  .copy_active, .download_active, .dual_port_ram_addr, .dual_port_ram_we);
